//--- eip_pkg.sv
package eip_pkg;

    // =====================================================
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NSRC   = 8;

    // =====================================================
    // Register indices, byte address is index times four
    localparam logic [9:0] PRIO_IDX = 10'h0f3;
    localparam logic [9:0] ENAB_IDX = 10'h0e6;
    localparam logic [9:0] STAT_IDX = 10'h0e7;

    // =====================================================
    // Reset values
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [7:0] ENAB_RST = 8'h00;

    // =====================================================
    // Source bit positions
    localparam int BIT_TIMER_THREE   = 7;
    localparam int BIT_COMPARATOR_B  = 6;
    localparam int BIT_COMPARATOR_A  = 5;
    localparam int BIT_COUNTER_ARRAY = 4;
    localparam int BIT_CONV_DONE     = 3;
    localparam int BIT_WINDOW_CMP    = 2;
    localparam int BIT_PORT_MATCH    = 1;
    localparam int BIT_TWO_WIRE_BUS  = 0;

    // =====================================================
    // Status field positions
    localparam int STAT_LO_ACT = 0;
    localparam int STAT_HI_ACT = 1;
    localparam int STAT_SRC_LO = 2;

    // =====================================================
    // Responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // =====================================================
    // Bus carriers
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } eip_axi_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } eip_axi_rsp_t;

endpackage

//--- eip_src_gate.sv
// =====================================================
// Per source mask and level split
module eip_src_gate (
    // Source
    input  wire logic i_req,
    input  wire logic i_en,
    input  wire logic i_prio,
    // Level requests
    output logic      o_hi,
    output logic      o_lo
);
    assign o_hi = i_req & i_en & i_prio;
    assign o_lo = i_req & i_en & ~i_prio;
endmodule

//--- eip_priority.sv
// Operation
// - Bit 7 sets timer three level
// - Bit 6 sets comparator b level
// - Bit 5 sets comparator a level
// - Bit 4 sets counter array level
// - Bit 3 sets conversion done level
// - Bit 2 sets window compare level
// - Bit 1 sets port match level
// - Bit 0 sets two wire bus level
// - All bits read/write, reset to low
// - Disabled source never reaches arbitration
//
// Implementation choice: the AXI4-Lite register port.
module eip_priority (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // Register bus
    input  wire eip_pkg::eip_axi_req_t  i_axi,
    output eip_pkg::eip_axi_rsp_t       o_axi,
    // Sources
    input  wire logic [7:0]             i_irq_req,
    // Core side
    input  wire logic                   i_irq_ack,
    input  wire logic                   i_irq_done,
    output logic                        o_irq_valid,
    output logic                        o_irq_high,
    output logic [2:0]                  o_irq_src,
    output logic [7:0]                  o_prio
);
    import eip_pkg::*;

    // =====================================================
    // State
    typedef struct packed {
        eip_axi_rsp_t      rsp;
        logic              aw_got;
        logic              w_got;
        logic [9:0]        widx;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic [7:0]        prio;
        logic [7:0]        enab;
        logic              lo_act;
        logic              hi_act;
        logic              irq_valid;
        logic              irq_high;
        logic [2:0]        irq_src;
    } eip_state_t;

    eip_state_t s_reg;
    eip_state_t s_next;
    logic [7:0] hi_req;
    logic [7:0] lo_req;
    logic       wr_fire;
    logic [7:0] live_req;

    // =====================================================
    // Source gating
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_src
            eip_src_gate u_gate (
                .i_req  (i_irq_req[g]),
                .i_en   (s_reg.enab[g]),
                .i_prio (s_reg.prio[g]),
                .o_hi   (hi_req[g]),
                .o_lo   (lo_req[g])
            );
        end
    endgenerate

    // =====================================================
    // Lowest index wins within a level
    function automatic logic [2:0] pick(input logic [7:0] v);
        logic [2:0] r;
        r = 3'd0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] rd_reg(input logic [9:0] idx, input eip_state_t st);
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            PRIO_IDX: r = st.prio;
            ENAB_IDX: r = st.enab;
            STAT_IDX: begin
                r[STAT_LO_ACT]              = st.lo_act;
                r[STAT_HI_ACT]              = st.hi_act;
                r[STAT_SRC_LO+2:STAT_SRC_LO] = st.irq_src;
            end
            default:  r = 8'h00;
        endcase
        return r;
    endfunction

    function automatic logic mapped(input logic [9:0] idx);
        return (idx == PRIO_IDX) || (idx == ENAB_IDX) || (idx == STAT_IDX);
    endfunction

    assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.rsp.bvalid;

    // Enabled requests, seen by the checks
    assign live_req = i_irq_req & s_reg.enab;

    // =====================================================
    // Next state
    always_comb begin
        s_next = s_reg;
        // Write address and data, either order
        if (i_axi.awvalid && s_reg.rsp.awready) begin
            s_next.aw_got      = 1'b1;
            s_next.widx        = i_axi.awaddr[ADDR_W-1:2];
            s_next.rsp.awready = 1'b0;
        end
        if (i_axi.wvalid && s_reg.rsp.wready) begin
            s_next.w_got      = 1'b1;
            s_next.wdata      = i_axi.wdata;
            s_next.wstrb      = i_axi.wstrb;
            s_next.rsp.wready = 1'b0;
        end
        if (wr_fire) begin
            s_next.aw_got     = 1'b0;
            s_next.w_got      = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp  = mapped(s_reg.widx) ? RESP_OKAY : RESP_SLVERR;
            if (s_reg.wstrb[0]) begin
                if (s_reg.widx == PRIO_IDX) begin
                    s_next.prio = s_reg.wdata[7:0];
                end
                if (s_reg.widx == ENAB_IDX) begin
                    s_next.enab = s_reg.wdata[7:0];
                end
            end
        end
        if (s_reg.rsp.bvalid && i_axi.bready) begin
            s_next.rsp.bvalid  = 1'b0;
            s_next.rsp.awready = 1'b1;
            s_next.rsp.wready  = 1'b1;
        end
        // Read
        if (i_axi.arvalid && s_reg.rsp.arready) begin
            s_next.rsp.arready = 1'b0;
            s_next.rsp.rvalid  = 1'b1;
            s_next.rsp.rdata   = {24'h00_0000, rd_reg(i_axi.araddr[ADDR_W-1:2], s_reg)};
            s_next.rsp.rresp   = mapped(i_axi.araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_reg.rsp.rvalid && i_axi.rready) begin
            s_next.rsp.rvalid  = 1'b0;
            s_next.rsp.arready = 1'b1;
        end
        // Service levels
        if (i_irq_done) begin
            if (s_reg.hi_act) begin
                s_next.hi_act = 1'b0;
            end else begin
                s_next.lo_act = 1'b0;
            end
        end
        if (i_irq_ack && s_reg.irq_valid) begin
            if (s_reg.irq_high) begin
                s_next.hi_act = 1'b1;
            end else begin
                s_next.lo_act = 1'b1;
            end
        end
        // Presentation to the core
        if ((|hi_req) && !s_next.hi_act) begin
            s_next.irq_valid = 1'b1;
            s_next.irq_high  = 1'b1;
            s_next.irq_src   = pick(hi_req);
        end else if ((|lo_req) && !s_next.hi_act && !s_next.lo_act) begin
            s_next.irq_valid = 1'b1;
            s_next.irq_high  = 1'b0;
            s_next.irq_src   = pick(lo_req);
        end else begin
            s_next.irq_valid = 1'b0;
            s_next.irq_high  = 1'b0;
        end
    end

    // =====================================================
    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_reg             <= '0;
            s_reg.rsp.awready <= 1'b1;
            s_reg.rsp.wready  <= 1'b1;
            s_reg.rsp.arready <= 1'b1;
            s_reg.prio        <= PRIO_RST;
            s_reg.enab        <= ENAB_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_axi       = s_reg.rsp;
    assign o_irq_valid = s_reg.irq_valid;
    assign o_irq_high  = s_reg.irq_high;
    assign o_irq_src   = s_reg.irq_src;
    assign o_prio      = s_reg.prio;

    // =====================================================
    // Checks
    property p_timer_three;
        @(posedge i_clk) disable iff (i_rst)
        (wr_fire && s_reg.wstrb[0] && s_reg.widx == PRIO_IDX) |=> (o_prio[7] == $past(s_reg.wdata[7]));
    endproperty
    a_timer_three: assert property (p_timer_three) else $error("timer three level not stored");

    property p_comparator_b;
        @(posedge i_clk) disable iff (i_rst)
        (!i_irq_ack && !i_irq_done && !s_reg.hi_act && (i_irq_req & s_reg.enab) == 8'h40 && s_reg.prio[6])
        |=> (o_irq_valid && o_irq_high && o_irq_src == 3'd6);
    endproperty
    a_comparator_b: assert property (p_comparator_b) else $error("comparator b not raised high");

    property p_comparator_a;
        @(posedge i_clk) disable iff (i_rst)
        (!i_irq_ack && !i_irq_done && !s_reg.hi_act && !s_reg.lo_act
         && (i_irq_req & s_reg.enab) == 8'h20 && !s_reg.prio[5])
        |=> (o_irq_valid && !o_irq_high && o_irq_src == 3'd5);
    endproperty
    a_comparator_a: assert property (p_comparator_a) else $error("comparator a not raised low");

    property p_counter_array;
        @(posedge i_clk) disable iff (i_rst)
        (i_axi.arvalid && o_axi.arready && i_axi.araddr[ADDR_W-1:2] == PRIO_IDX)
        |=> (o_axi.rvalid && o_axi.rdata[4] == $past(o_prio[4]));
    endproperty
    a_counter_array: assert property (p_counter_array) else $error("counter array bit read wrong");

    property p_conv_done;
        @(posedge i_clk) disable iff (i_rst)
        (wr_fire && s_reg.wstrb[0] && s_reg.widx == PRIO_IDX) ##1 o_axi.bvalid
        |-> (o_prio[3] == $past(s_reg.wdata[3]));
    endproperty
    a_conv_done: assert property (p_conv_done) else $error("conversion done level not stored");

    property p_window_cmp;
        @(posedge i_clk) disable iff (i_rst)
        ($changed(o_prio[2])) |-> $past(wr_fire && s_reg.widx == PRIO_IDX);
    endproperty
    a_window_cmp: assert property (p_window_cmp) else $error("window compare level changed alone");

    property p_port_match;
        @(posedge i_clk) disable iff (i_rst)
        (wr_fire && s_reg.wstrb[0] && s_reg.widx == PRIO_IDX) |=> ##1 (o_prio[1] == $past(s_reg.wdata[1], 2));
    endproperty
    a_port_match: assert property (p_port_match) else $error("port match level not stored");

    property p_two_wire_bus;
        @(posedge i_clk) disable iff (i_rst)
        (wr_fire && !s_reg.wstrb[0]) |=> $stable(o_prio[0]);
    endproperty
    a_two_wire_bus: assert property (p_two_wire_bus) else $error("two wire bus level took masked write");

    property p_reset_low;
        @(posedge i_clk) i_rst |=> (o_prio == 8'h00 && !o_irq_valid);
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("levels not low after reset");

    property p_masked;
        @(posedge i_clk) disable iff (i_rst)
        o_irq_valid |-> ((($past(live_req) >> o_irq_src) & 8'h01) == 8'h01);
    endproperty
    a_masked: assert property (p_masked) else $error("disabled source presented");

    property p_preempt;
        @(posedge i_clk) disable iff (i_rst)
        (s_reg.hi_act && !i_irq_done) |=> !(o_irq_valid && !o_irq_high) ##0 !(o_irq_valid && o_irq_high && $past(s_reg.hi_act));
    endproperty
    a_preempt: assert property (p_preempt) else $error("equal or lower level preempted");

    property p_two_wire_bus_store;
        @(posedge i_clk) disable iff (i_rst)
        (wr_fire && s_reg.wstrb[0] && s_reg.widx == PRIO_IDX) |=> (o_prio[0] == $past(s_reg.wdata[0]));
    endproperty
    a_two_wire_bus_store: assert property (p_two_wire_bus_store) else $error("two wire bus level not stored");

    property p_window_store;
        @(posedge i_clk) disable iff (i_rst)
        (wr_fire && s_reg.wstrb[0] && s_reg.widx == PRIO_IDX) |=> (o_prio[2] == $past(s_reg.wdata[2]));
    endproperty
    a_window_store: assert property (p_window_store) else $error("window compare level not stored");

    property p_prio_read;
        @(posedge i_clk) disable iff (i_rst)
        (i_axi.arvalid && o_axi.arready && i_axi.araddr[ADDR_W-1:2] == PRIO_IDX)
        |=> (o_axi.rdata == {24'h00_0000, $past(o_prio)});
    endproperty
    a_prio_read: assert property (p_prio_read) else $error("priority byte read wrong");

    property p_lo_blocked;
        @(posedge i_clk) disable iff (i_rst)
        (s_reg.lo_act && !i_irq_done) |=> !(o_irq_valid && !o_irq_high);
    endproperty
    a_lo_blocked: assert property (p_lo_blocked) else $error("low preempted low service");

    property p_hi_over_lo;
        @(posedge i_clk) disable iff (i_rst)
        (s_reg.lo_act && !s_reg.hi_act && !i_irq_ack && !i_irq_done && (hi_req != 8'h00))
        |=> (o_irq_valid && o_irq_high);
    endproperty
    a_hi_over_lo: assert property (p_hi_over_lo) else $error("high did not preempt low service");

endmodule

//--- eip_core_model.sv
// =====================================================
// Core side: takes presented interrupts, ends service
module eip_core_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Controller side
    input  wire logic       i_valid,
    input  wire logic       i_finish,
    input  wire logic [3:0] i_lat,
    output logic            o_ack,
    output logic            o_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_reg;

    // =====================================================
    // Ack after i_lat cycles, never when all ones
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wait_reg <= 4'h0;
            o_ack    <= 1'b0;
            o_done   <= 1'b0;
        end else begin
            o_done <= i_finish;
            o_ack  <= 1'b0;
            if (i_valid && !o_ack && i_lat != 4'hf) begin
                if (wait_reg >= i_lat) begin
                    o_ack    <= 1'b1;
                    wait_reg <= 4'h0;
                end else begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end else begin
                wait_reg <= 4'h0;
            end
        end
    end
endmodule

//--- extended_irq_priority_one_tb.sv
module extended_irq_priority_one_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import eip_pkg::*;
    logic         i_clk   = 1'b0;
    logic         i_rst   = 1'b1;
    eip_axi_req_t axi_req = '0;
    eip_axi_rsp_t axi_rsp;
    logic [7:0]   irq_req = 8'h00;
    logic         fin     = 1'b0;
    logic [3:0]   lat     = 4'hf;
    logic         ack, done, irq_valid, irq_high;
    logic [2:0]   irq_src;
    logic [7:0]   prio, p, en;
    logic [31:0]  d;
    logic [1:0]   r;
    int           err_count    = 0;
    int           total_checks = 0;

    always #12.5 i_clk = ~i_clk;

    eip_priority eip_priority_i (.i_clk(i_clk), .i_rst(i_rst), .i_axi(axi_req), .o_axi(axi_rsp),
        .i_irq_req(irq_req), .i_irq_ack(ack), .i_irq_done(done), .o_irq_valid(irq_valid),
        .o_irq_high(irq_high), .o_irq_src(irq_src), .o_prio(prio));
    eip_core_model eip_core_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_valid(irq_valid),
        .i_finish(fin), .i_lat(lat), .o_ack(ack), .o_done(done));

    // =====================================================
    // Expectations
    function automatic logic [4:0] pres(input logic [7:0] q, input logic [7:0] e, input logic [7:0] pr);
        logic [7:0] m;
        logic [7:0] s;
        logic [2:0] k;
        m = q & e;
        s = ((m & pr) != 8'h00) ? (m & pr) : m;
        k = 3'h0;
        for (int i = 7; i >= 0; i--) if (s[i]) k = 3'(i);
        return {m != 8'h00, (m & pr) != 8'h00, k};
    endfunction

    // =====================================================
    // Compare and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_irq(input logic [4:0] exp);
        logic [4:0] got;
        got = exp[4] ? {irq_valid, irq_high, irq_src} : {irq_valid, 4'h0};
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] v, input logic [3:0] s);
        bit pa, pw, pb;
        @(posedge i_clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= {idx, 2'b00};
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= v;
        axi_req.wstrb   <= s;
        axi_req.bready  <= 1'b1;
        pa = 1;
        pw = 1;
        pb = 1;
        while (pb) begin
            @(posedge i_clk);
            if (pa && axi_rsp.awready) begin
                pa = 0;
                axi_req.awvalid <= 1'b0;
            end
            if (pw && axi_rsp.wready) begin
                pw = 0;
                axi_req.wvalid <= 1'b0;
            end
            if (!pa && !pw && axi_rsp.bvalid) begin
                pb = 0;
                r = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [9:0] idx);
        bit pa, pr;
        @(posedge i_clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= {idx, 2'b00};
        axi_req.rready  <= 1'b1;
        pa = 1;
        pr = 1;
        while (pr) begin
            @(posedge i_clk);
            if (pa && axi_rsp.arready) begin
                pa = 0;
                axi_req.arvalid <= 1'b0;
            end else if (!pa && axi_rsp.rvalid) begin
                pr = 0;
                d = axi_rsp.rdata;
                r = axi_rsp.rresp;
                axi_req.rready <= 1'b0;
            end
        end
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic summarize;
        if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // =====================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        summarize();
    end

    // =====================================================
    // Tests
    initial begin
        void'($urandom(13));
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(PRIO_IDX);
        chk(d, 32'h0000_0000);
        chk({24'h0, prio}, {24'h0, PRIO_RST});
        for (int b = 0; b < 8; b++) begin
            wr(PRIO_IDX, 32'h1 << b, 4'hf);
            rd(PRIO_IDX);
            chk(d, 32'h1 << b);
            chk({24'h0, prio}, 32'h1 << b);
        end
        p = 8'($urandom);
        wr(PRIO_IDX, {24'h0, p}, 4'hf);
        wr(PRIO_IDX, {24'h0, ~p}, 4'h0);
        rd(PRIO_IDX);
        chk(d, {24'h0, p});
        wr(10'h001, 32'h0000_00ff, 4'hf);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rd(10'h001);
        chk({d[31:2], r}, {30'h0, RESP_SLVERR});
        @(posedge i_clk);
        irq_req <= 8'hff;
        look(3);
        chk_irq(5'h00);
        for (int b = 0; b < 8; b++) begin
            wr(ENAB_IDX, 32'h1 << b, 4'hf);
            look(2);
            chk_irq(pres(8'hff, 8'h1 << b, p));
        end
        for (int n = 0; n < 24; n++) begin
            p = 8'($urandom);
            en = 8'($urandom);
            wr(PRIO_IDX, {24'h0, p}, 4'hf);
            wr(ENAB_IDX, {24'h0, en}, 4'hf);
            @(posedge i_clk);
            irq_req <= 8'($urandom);
            look(2);
            chk_irq(pres(irq_req, en, p));
        end
        wr(PRIO_IDX, 32'h0000_0060, 4'hf);
        wr(ENAB_IDX, 32'h0000_00ff, 4'hf);
        @(posedge i_clk);
        irq_req <= 8'h08;
        lat     <= 4'h2;
        look(8);
        chk_irq(5'h00);
        @(posedge i_clk);
        irq_req <= 8'h28;
        lat     <= 4'h0;
        look(1);
        chk_irq(5'h1d);
        look(4);
        rd(STAT_IDX);
        chk({27'h0, d[4:0]}, 32'h0000_0017);
        @(posedge i_clk);
        irq_req <= 8'h68;
        lat     <= 4'hf;
        look(3);
        chk_irq(5'h00);
        @(posedge i_clk);
        fin <= 1'b1;
        @(posedge i_clk);
        fin <= 1'b0;
        look(3);
        chk_irq(5'h1d);
        summarize();
    end
endmodule
